/* cgt_current_path.sv */
// Purpose: current channel filter, gain and shunt drift compensation
// Assumes: front end data changes after strobe rises, stable until it falls
// Notes:   output words leave through a two-entry buffer
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "cgt_regs.svh"

// How it works
// - serial modulator bits filtered into 24-bit codes
// - strobe is clock divided by four
// - signed 24-bit results at output rate
// - codes use the whole signed range
// - full scale near 8.39M (2^23), no trimming
// - sample times one plus gain over 2^23
// - gain-adjusted sample feeds every later use
// - gain reads sign extended, four zeros below
// - one drift coefficient for all channels
// - second factor from coefficient and heat difference
// - per-channel reference and measured heat held
// - heat stored 1.024 s after select low
// - compensation then active at sample rate
// - select bits default one, low measures heat
module cgt_current_path
	import cgt_pkg::*;
#(
	parameter int unsigned TEMP_SETTLE_CYCLES =
		`CGT_TEMP_SETTLE_MS * (`CGT_CLK_FREQ_HZ / 1000)
)
(
	input  wire logic        clk,
	input  wire logic        srst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// front end link
	output logic             strobeClk,
	input  wire logic [3:0]  currentData,
	input  wire logic [3:0]  secondData,
	output logic [3:0]       selectLine,
	// sample stream
	output logic             smpValid,
	output cgt_sample_t      smpData,
	input  wire logic        smpReady
);

	localparam int unsigned STROBE_DIV = `CGT_IN_CLK_KHZ / `CGT_SAMPLE_KHZ;
	localparam int unsigned DEC_RATIO =
		(`CGT_SAMPLE_KHZ * 1000) / `CGT_OUT_RATE_SPS;
	localparam cgt_state_t ST_RESET = '{selBits: `CGT_CTRL_RESET, default: '0};

	cgt_state_t s_reg;
	cgt_state_t s_next;

	// clamp a wide signed value to the 24-bit signed range
	function automatic cgt_word_t sat24(input logic signed [49:0] v);
		if (v > 50'(`CGT_POS_MAX))
			return `CGT_POS_MAX;
		else if (v < 50'(`CGT_NEG_MAX))
			return `CGT_NEG_MAX;
		else
			return v[23:0];
	endfunction : sat24

	// read view of one register at a byte offset
	function automatic logic [32:0] read_word(input cgt_state_t s, input logic [7:0] a);
		logic [32:0] r;
		r = {1'b1, 32'h0};
		if (a == `CGT_SHUNT_DRIFT_COEFFICIENT_ADDR)
			r = {1'b0, 8'h0, s.shunt_drift_coefficient};
		else if (a == `CGT_CTRL_ADDR)
			r = {1'b0, 28'h0, s.selBits};
		else if (a == `CGT_STATUS_ADDR)
			r = {1'b0, 27'h0, s.overrun, s.compActive};
		for (int c = 0; c < 4; c++)
		begin
			if (a == `CGT_GAIN_BASE + 8'(c) * `CGT_WORD_STEP)
				r = {1'b0, {4{s.gain[c][23]}}, s.gain[c], 4'h0};
			else if (a == `CGT_REF_BASE + 8'(c) * `CGT_WORD_STEP)
				r = {1'b0, 8'h0, s.refHeat[c]};
			else if (a == `CGT_SHUNT_BASE + 8'(c) * `CGT_WORD_STEP)
				r = {1'b0, 8'h0, s.shuntHeat[c]};
		end
		return r;
	endfunction : read_word

	// next state of the whole block
	always_comb
	begin
		logic                tick;
		logic                decim;
		logic                pop;
		logic                push;
		logic                apbWr;
		logic                bitIn;
		logic [32:0]         rd;
		cgt_acc_t            inc;
		cgt_acc_t            c1;
		cgt_acc_t            c2;
		cgt_acc_t            c3;
		cgt_word_t [7:0]     fOut;
		cgt_sample_t         newSmp;
		logic signed [24:0]  gf;
		logic signed [48:0]  pg;
		cgt_word_t           yg;
		logic signed [24:0]  dt;
		logic signed [48:0]  pt;
		logic signed [25:0]  q;
		logic signed [49:0]  pc;
		logic signed [26:0]  corr;
		logic signed [49:0]  yt;
		tick = 1'b0;
		decim = 1'b0;
		pop = 1'b0;
		push = 1'b0;
		apbWr = 1'b0;
		bitIn = 1'b0;
		rd = '0;
		inc = '0;
		c1 = '0;
		c2 = '0;
		c3 = '0;
		fOut = '0;
		newSmp = '0;
		gf = '0;
		pg = '0;
		yg = '0;
		dt = '0;
		pt = '0;
		q = '0;
		pc = '0;
		corr = '0;
		yt = '0;
		s_next = s_reg;

		// strobe divider: high on counts 2 and 3, so reset leaves no short first pulse;
		// bits are sampled as the strobe falls, two cycles after the front end moved them
		s_next.divCnt = s_reg.divCnt + 2'(1);
		s_next.strobe = (s_next.divCnt >= `CGT_DIV_HALF);
		tick = (s_reg.divCnt == `CGT_DIV_LAST);
		decim = tick && (s_reg.decCnt == `CGT_DEC_LAST);
		if (tick)
			s_next.decCnt = s_reg.decCnt + 7'(1);

		// third order sinc filters, one bit per strobe, one word per 128 bits
		for (int f = 0; f < 8; f++)
		begin
			// an unused neutral line held high reads as steady positive full scale
			bitIn = (f < 4) ? currentData[f] : secondData[f - 4];
			inc = bitIn ? `CGT_BIT_ONE : -`CGT_BIT_ONE;
			if (tick)
			begin
				s_next.int1[f] = s_reg.int1[f] + inc;
				s_next.int2[f] = s_reg.int2[f] + s_reg.int1[f];
				s_next.int3[f] = s_reg.int3[f] + s_reg.int2[f];
			end
			c1 = s_reg.int3[f] - s_reg.dly1[f];
			c2 = c1 - s_reg.dly2[f];
			c3 = c2 - s_reg.dly3[f];
			// +/-2^21 scaled to the full code range, no trim of unit spread
			fOut[f] = sat24(50'(c3) <<< `CGT_FILT_SHIFT);
			if (decim)
			begin
				s_next.dly1[f] = s_reg.int3[f];
				s_next.dly2[f] = c1;
				s_next.dly3[f] = c2;
			end
		end

		// heat measurement per channel, driven by the select bits
		for (int c = 0; c < 4; c++)
		begin
			if (s_reg.selBits[c])
			begin
				s_next.settleCnt[c] = '0;
				s_next.compActive[c] = 1'b0;
			end
			else if (s_reg.settleCnt[c] < 32'(TEMP_SETTLE_CYCLES))
				s_next.settleCnt[c] = s_reg.settleCnt[c] + 32'(1);
			else if (decim)
			begin
				s_next.shuntHeat[c] = fOut[4 + c];
				s_next.compActive[c] = 1'b1;
			end
		end

		// converted words wait here until the buffer has room
		if (decim)
		begin
			s_next.rawValid = 1'b1;
			for (int c = 0; c < 4; c++)
				s_next.rawCur[c] = fOut[c];
		end

		// gain then heat factor per channel
		for (int c = 0; c < 4; c++)
		begin
			gf = `CGT_UNITY_Q23 + 25'(s_reg.gain[c]);
			pg = s_reg.rawCur[c] * gf;
			yg = sat24(50'(pg >>> `CGT_FRAC_SHIFT));
			dt = 25'(s_reg.shuntHeat[c]) - 25'(s_reg.refHeat[c]);
			pt = s_reg.shunt_drift_coefficient * dt;
			q = 26'(pt >>> `CGT_FRAC_SHIFT);
			pc = yg * q;
			corr = 27'(pc >>> `CGT_FRAC_SHIFT);
			yt = 50'(yg) - 50'(corr);
			newSmp.ch[c] = s_reg.compActive[c] ? sat24(yt) : yg;
		end

		// two-entry buffer, head entry drives the stream port
		pop = s_reg.v0 && smpReady;
		push = s_reg.rawValid && (!s_reg.v1 || pop);
		if (pop)
		begin
			s_next.buf0 = s_reg.buf1;
			s_next.v0 = s_reg.v1;
			s_next.v1 = 1'b0;
		end
		if (push)
		begin
			if (!s_next.v0)
			begin
				s_next.buf0 = newSmp;
				s_next.v0 = 1'b1;
			end
			else
			begin
				s_next.buf1 = newSmp;
				s_next.v1 = 1'b1;
			end
			if (!decim)
				s_next.rawValid = 1'b0;
		end
		if (decim && s_reg.rawValid && !push)
			s_next.overrun = 1'b1;

		// apb: answer one cycle after setup, write at the access edge
		s_next.pready = psel && !penable;
		apbWr = psel && penable && s_reg.pready && pwrite;
		if (psel && !penable)
		begin
			rd = read_word(s_reg, paddr);
			s_next.pslverr = rd[32] || (paddr[1:0] != 2'h0);
			s_next.prdata = (pwrite || s_next.pslverr) ? 32'h0 : rd[31:0];
		end
		else if (s_reg.pready)
		begin
			s_next.pslverr = 1'b0;
			s_next.prdata = '0;
		end
		if (apbWr && !s_reg.pslverr)
		begin
			if (paddr == `CGT_SHUNT_DRIFT_COEFFICIENT_ADDR)
				s_next.shunt_drift_coefficient = pwdata[23:0];
			else if (paddr == `CGT_CTRL_ADDR)
				s_next.selBits = pwdata[3:0];
			else if (paddr == `CGT_STATUS_ADDR)
				s_next.overrun = (s_next.overrun && !pwdata[`CGT_STATUS_OVR_BIT]) ||
					(decim && s_reg.rawValid && !push); // a new overrun wins over clear
			for (int c = 0; c < 4; c++)
			begin
				if (paddr == `CGT_GAIN_BASE + 8'(c) * `CGT_WORD_STEP)
					s_next.gain[c] = pwdata[27:4];
				else if (paddr == `CGT_REF_BASE + 8'(c) * `CGT_WORD_STEP)
					s_next.refHeat[c] = pwdata[23:0];
			end
		end
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (srst)
			s_reg <= ST_RESET;
		else
			s_reg <= s_next;
	end

	// outputs straight from the state register
	assign prdata     = s_reg.prdata;
	assign pready     = s_reg.pready;
	assign pslverr    = s_reg.pslverr;
	assign strobeClk  = s_reg.strobe;
	assign selectLine = s_reg.selBits;
	assign smpValid   = s_reg.v0;
	assign smpData    = s_reg.buf0;

endmodule : cgt_current_path
`default_nettype wire

/* cgt_regs.svh */
// Purpose: constants of the current gain and shunt drift datapath
// Assumes: 200 MHz system clock, APB register access
// Notes:   byte offsets are word aligned
`ifndef CGT_REGS_SVH
`define CGT_REGS_SVH

// clock and timing
`define CGT_CLK_FREQ_HZ      200000000
`define CGT_IN_CLK_KHZ       4096
`define CGT_SAMPLE_KHZ       1024
`define CGT_OUT_RATE_SPS     8000
`define CGT_TEMP_SETTLE_MS   1024
`define CGT_DIV_W            2
`define CGT_DIV_LAST         2'h3
`define CGT_DIV_HALF         2'h2
`define CGT_DEC_W            7
`define CGT_DEC_LAST         7'h7f

// arithmetic
`define CGT_UNITY_Q23        25'sh0800000
`define CGT_FRAC_SHIFT       23
`define CGT_FILT_SHIFT       2
`define CGT_BIT_ONE          32'sh00000001
`define CGT_POS_MAX          24'sh7fffff
`define CGT_NEG_MAX          24'sh800000

// register byte offsets
`define CGT_GAIN_BASE        8'h00
`define CGT_SHUNT_DRIFT_COEFFICIENT_ADDR      8'h10
`define CGT_REF_BASE         8'h14
`define CGT_SHUNT_BASE       8'h24
`define CGT_CTRL_ADDR        8'h34
`define CGT_STATUS_ADDR      8'h38
`define CGT_WORD_STEP        8'h04

// reset values and fields
`define CGT_CTRL_RESET       4'hf
`define CGT_STATUS_OVR_BIT   4

`endif

/* cgt_pkg.sv */
// Purpose: types of the current gain and shunt drift datapath
// Assumes: four channels, order a, b, c, neutral
// Notes:   filters 0..3 carry current streams, 4..7 second streams
package cgt_pkg;

	typedef logic signed [23:0] cgt_word_t;
	typedef logic signed [31:0] cgt_acc_t;

	// one output word: all four channels of one conversion
	typedef struct packed {
		cgt_word_t [3:0] ch;
	} cgt_sample_t;

	// whole state of the datapath
	typedef struct packed {
		logic [1:0]       divCnt;
		logic             strobe;
		logic [6:0]       decCnt;
		cgt_acc_t [7:0]   int1;
		cgt_acc_t [7:0]   int2;
		cgt_acc_t [7:0]   int3;
		cgt_acc_t [7:0]   dly1;
		cgt_acc_t [7:0]   dly2;
		cgt_acc_t [7:0]   dly3;
		logic             rawValid;
		cgt_word_t [3:0]  rawCur;
		cgt_word_t [3:0]  gain;
		cgt_word_t [3:0]  refHeat;
		cgt_word_t [3:0]  shuntHeat;
		cgt_word_t        shunt_drift_coefficient;
		logic [3:0]       selBits;
		logic [3:0]       compActive;
		logic [3:0][31:0] settleCnt;
		logic             overrun;
		logic             v0;
		logic             v1;
		cgt_sample_t      buf0;
		cgt_sample_t      buf1;
		logic             pready;
		logic             pslverr;
		logic [31:0]      prdata;
	} cgt_state_t;

endpackage : cgt_pkg

/* cgt_current_path_props.sv */
// Purpose: port checker of the current path
// Assumes: one clock, srst synchronous active high
// Notes:   bound into every current path instance
`timescale 1ns/1ps
`default_nettype none
module cgt_current_path_props
	import cgt_pkg::*;
#(
	parameter int unsigned TEMP_SETTLE_CYCLES = 2000
)
(
	input wire logic        clk,
	input wire logic        srst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        strobeClk,
	input wire logic [3:0]  currentData,
	input wire logic [3:0]  secondData,
	input wire logic [3:0]  selectLine,
	input wire logic        smpValid,
	input wire cgt_sample_t smpData,
	input wire logic        smpReady
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// strobe and select lines
	a_strobe_div: assert property ($rose(strobeClk) |=>
		strobeClk ##1 !strobeClk [*2] ##1 strobeClk)
		else $error("strobe is not clock over four");
	a_sel_reset: assert property ($fell(srst) |-> selectLine == 4'hf)
		else $error("select lines not high after reset");
	a_sel_write: assert property ($changed(selectLine) |->
		$past(psel && penable && pready && pwrite && paddr == 8'h34))
		else $error("select lines changed without a control write");
	// register bus answer
	a_ready_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_once: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_addr: assert property (psel && !penable && (paddr[1:0] != 2'h0 || paddr > 8'h38) |=> pslverr)
		else $error("bad address not refused");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	// sample stream holds until taken
	a_word_hold: assert property (smpValid && !smpReady |=> smpValid && $stable(smpData))
		else $error("sample word dropped while stalled");
	c_take: cover property (smpValid && smpReady);
	c_refuse: cover property (pready && pslverr);
	c_heat: cover property (selectLine == 4'h0);
endmodule : cgt_current_path_props

bind cgt_current_path cgt_current_path_props #(.TEMP_SETTLE_CYCLES(TEMP_SETTLE_CYCLES)) u_props (
	.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .strobeClk(strobeClk),
	.currentData(currentData), .secondData(secondData), .selectLine(selectLine),
	.smpValid(smpValid), .smpData(smpData), .smpReady(smpReady));
`default_nettype wire

/* cgt_front_model.sv */
// Purpose: behavioural front ends of the four channels
// Assumes: bits change shortly after the strobe rises
// Notes:   level gives each current stream a constant bit
`timescale 1ns/1ps
`default_nettype none
module cgt_front_model
(
	input  wire logic       strobeClk,
	input  wire logic [3:0] level,
	input  wire logic [3:0] selectLine,
	output logic      [3:0] currentData,
	output logic      [3:0] secondData
);
	initial currentData = 4'hf;
	initial secondData = 4'h0;
	// current bits follow level; second bits toggle as a voltage, sensor gives all ones
	always @(posedge strobeClk)
	begin
		currentData <= #1 level;
		secondData  <= #1 (~secondData & selectLine) | ~selectLine;
	end
endmodule : cgt_front_model
`default_nettype wire

/* testbench.sv */
// Purpose: self-checking bench of the current path
// Assumes: settle count shortened to 2000 cycles
// Notes:   constant bit streams give exact expected codes
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import cgt_pkg::*;
	logic        clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, smpReady = 0, e;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic        pready, pslverr, strobeClk, smpValid;
	logic [3:0]  currentData, secondData, selectLine, lvl = 4'hf;
	cgt_sample_t smpData, s;
	logic [23:0] gn [4], rf [4], tc = 0;
	logic [23:0] cg [3] = '{24'h0, 24'h400000, 24'hc00000};
	int          n_mismatch = 0, checked = 0;
	always #2.5 clk = ~clk;
	cgt_current_path #(.TEMP_SETTLE_CYCLES(2000)) uut (.clk(clk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .strobeClk(strobeClk), .currentData(currentData),
		.secondData(secondData), .selectLine(selectLine), .smpValid(smpValid),
		.smpData(smpData), .smpReady(smpReady));
	cgt_front_model u_fe (.strobeClk(strobeClk), .level(lvl), .selectLine(selectLine),
		.currentData(currentData), .secondData(secondData));
	task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
		checked++;
		if (g !== x)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, x, g);
		end
	endtask : chk
	// one apb transfer, held until ready
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		int n = 0;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) n_mismatch++;
	endtask : apb
	// take one sample word after a random stall
	task automatic getw();
		int n = 0;
		repeat ($urandom_range(0, 30)) @(posedge clk);
		smpReady <= 1'b1;
		do @(posedge clk); while (smpValid !== 1'b1 && ++n < 2000);
		s = smpData;
		smpReady <= 1'b0;
		@(posedge clk);
		if (n >= 2000) n_mismatch++;
	endtask : getw
	function automatic longint sat(longint v);
		return v > 64'sh7fffff ? 64'sh7fffff : v < -64'sh800000 ? -64'sh800000 : v;
	endfunction : sat
	// expected code: gain factor, then drift factor with sensor at full scale
	function automatic cgt_word_t expc(logic lv, logic [23:0] g, logic [23:0] rr, logic act);
		longint y;
		longint q;
		y = sat(((lv ? 64'sh7fffff : -64'sh800000) * (longint'($signed(g)) + 64'sh800000)) >>> 23);
		q = (longint'($signed(tc)) * (64'sh7fffff - longint'($signed(rr)))) >>> 23;
		if (act) y = sat(y - ((y * q) >>> 23));
		return cgt_word_t'(y);
	endfunction : expc
	task automatic cmpw(logic act);
		repeat (6) getw();
		for (int c = 0; c < 4; c++)
			chk("sample", expc(lvl[c], gn[c], rf[c], act), s.ch[c]);
	endtask : cmpw
	task automatic results();
		if (n_mismatch == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results
	initial
	begin
		#500000;
		n_mismatch++;
		results();
	end
	// main sequence: registers, gain corners and random gains, overrun, drift
	initial
	begin
		void'($urandom(32'h2d6eb653));
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		apb(0, 8'h34, 0);
		chk("control", 32'hf, r);
		chk("select", 32'hf, selectLine);
		apb(0, 8'h3c, 0);
		chk("unmapped", 1, e);
		apb(1, 8'h26, 0);
		chk("unaligned", 1, e);
		apb(1, 8'h24, 32'h55);
		apb(0, 8'h24, 0);
		chk("heat ro", 0, r);
		for (int i = 0; i < 9; i++)
		begin
			for (int c = 0; c < 4; c++) gn[c] = i < 3 ? cg[i] : 24'($urandom);
			lvl <= i < 3 ? 4'ha ^ 4'(i) : 4'($urandom);
			for (int c = 0; c < 4; c++) apb(1, 8'(4 * c), {{4{gn[c][23]}}, gn[c], 4'h0});
			apb(0, 8'h04, 0);
			chk("gain", {{4{gn[1][23]}}, gn[1], 4'h0}, r);
			cmpw(0);
		end
		repeat (2600) @(posedge clk);
		apb(0, 8'h38, 0);
		chk("overrun", 1, r[4]);
		repeat (4) getw();
		apb(1, 8'h38, 32'h10);
		apb(0, 8'h38, 0);
		chk("overrun clear", 0, r[4]);
		tc = 24'($urandom_range(0, 32'h7fffff));
		apb(1, 8'h10, {8'h0, tc});
		for (int c = 0; c < 4; c++) rf[c] = 24'($urandom);
		for (int c = 0; c < 4; c++) apb(1, 8'(20 + 4 * c), {8'h0, rf[c]});
		apb(1, 8'h34, 0);
		@(posedge clk);
		chk("select low", 0, selectLine);
		apb(0, 8'h38, 0);
		chk("active early", 0, r[3:0]);
		repeat (2700) @(posedge clk);
		apb(0, 8'h38, 0);
		chk("active", 32'hf, r[3:0]);
		apb(0, 8'h30, 0);
		chk("heat", 32'h7fffff, r);
		cmpw(1);
		apb(1, 8'h34, 32'hf);
		apb(0, 8'h38, 0);
		chk("inactive", 0, r[3:0]);
		results();
	end
endmodule : testbench
`default_nettype wire
